/* rtl/lps_pkg.sv */
// Purpose: shared constants for the panel link ends
// Assumes: 100 MHz system clock on both ends
// Notes:   frame geometry and power sequencing figures
package lps_pkg;
    localparam int CLK_MHZ          = 100;
    localparam int CHAN_W           = 6;
    localparam int PIX_W            = 3 * CHAN_W;
    localparam int RED_LSB          = 0;
    localparam int GREEN_LSB        = 6;
    localparam int BLUE_LSB         = 12;
    localparam int LINE_DOTS        = 336;
    localparam int FRAME_LINES      = 244;
    localparam int HBP_DOTS         = 8;
    localparam int HDISP_DOTS       = 320;
    localparam int VBP_LINES        = 2;
    localparam int VDISP_LINES      = 240;
    localparam int HSYNC_DOTS       = 1;
    localparam int VSYNC_LINES      = 1;
    localparam int START_FRAMES     = 10;
    localparam int OFF_FRAMES       = 2;
    localparam int SER_BITS         = 9;
    localparam bit FLAG_DATA        = 1'b1;
    localparam int T_SHUT_ON_MS     = 164;
    localparam int T_SETTLE_US      = 1;
    localparam int T_RES_US         = 10;
    localparam int SHUT_ON_CYC      = T_SHUT_ON_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYC       = T_SETTLE_US * CLK_MHZ;
    localparam int RES_CYC          = T_RES_US * CLK_MHZ;
endpackage : lps_pkg

/* rtl/lps_link_if.sv */
// Purpose: pixel, sync, power and serial wires between host and panel
// Assumes: every wire is driven by the host end only
// Notes:   no clocking block; the bench joins the two ends here
`timescale 1ns/1ps
`default_nettype none
interface lps_link_if;
    logic        pixel_clock_in;
    logic        horizontal_sync;
    logic        vertical_sync;
    logic [17:0] pixel_data;
    logic        shutdown;
    logic        panel_reset_n;
    logic        serial_select_n;
    logic        serial_clock;
    logic        serial_data_in;
    modport host (output pixel_clock_in, horizontal_sync, vertical_sync, pixel_data,
                  shutdown, panel_reset_n, serial_select_n, serial_clock, serial_data_in);
    modport dev  (input  pixel_clock_in, horizontal_sync, vertical_sync, pixel_data,
                  shutdown, panel_reset_n, serial_select_n, serial_clock, serial_data_in);
endinterface : lps_link_if
`default_nettype wire

/* rtl/lps_sync2.sv */
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: bits are independent levels; no bus coherence
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lps_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lps_sync_regs_type;

    lps_sync_regs_type r_ff;
    lps_sync_regs_type nxt_r;

    if (W < 1) begin : g_bad_w
        $error("lps_sync2: width must be positive");
    end

    always_comb begin
        nxt_r        = r_ff;
        nxt_r.meta   = d_i;
        nxt_r.stable = r_ff.meta;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign q_o = r_ff.stable;
endmodule : lps_sync2
`default_nettype wire

/* rtl/lps_panel_dev.sv */
// Purpose: panel end: power sequencing, serial command port, pixel capture
// Assumes: all link wires come from another clock domain
// Notes:   link clocks are oversampled by CLK_I, not used as clocks
// Rules of the panel link
// - host runs dot clock before shutdown low
// - host holds shutdown high one microsecond first
// - panel power up within 164 ms
// - display starts by tenth vsync fall
// - delays counted in frames of 244 lines
// - blank at second vsync fall after shutdown
// - host keeps dot clock two frames
// - host resets only after two frames
// - serial word framed by low chip select
// - nine bit word with command/data flag
// - six bit channels, bit five brightest
// - eighteen bit pixel bus, three channels
// - active high data, zero is black
`timescale 1ns/1ps
`default_nettype none
module lps_panel_dev
    import lps_pkg::*;
#(
    parameter int RAMP_CYC = SHUT_ON_CYC
) (
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    lps_link_if.dev                LINK,
    output logic                   PANEL_POWER_O,
    output logic                   DISPLAY_ON_O,
    output logic [CHAN_W-1:0]      PIX_RED_O,
    output logic [CHAN_W-1:0]      PIX_GREEN_O,
    output logic [CHAN_W-1:0]      PIX_BLUE_O,
    output logic                   PIX_STROBE_O,
    output logic                   SER_WORD_VALID_O,
    output logic                   SER_IS_DATA_O,
    output logic [7:0]             SER_BYTE_O
);
    localparam int TW     = $clog2(RAMP_CYC + 1);
    localparam int SYNC_W = 7 + PIX_W;

    typedef enum logic [3:0] {
        D_OFF  = 4'h1,
        D_RAMP = 4'h2,
        D_SHOW = 4'h4,
        D_FADE = 4'h8
    } lps_dev_state_type;

    typedef struct packed {
        lps_dev_state_type st;
        logic [3:0]        vcnt;
        logic [TW-1:0]     tmr;
        logic              pwr;
        logic              dclk_q;
        logic              vs_q;
        logic              sclk_q;
        logic [3:0]        bitcnt;
        logic [SER_BITS-1:0] sh;
        logic              wvalid;
        logic              is_data;
        logic [7:0]        byte_q;
        logic [PIX_W-1:0]  pix;
        logic              pstb;
    } lps_dev_regs_type;

    lps_dev_regs_type r_ff;
    lps_dev_regs_type nxt_r;

    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] synced;
    logic [PIX_W-1:0]  s_pix;
    logic              s_sdi;
    logic              s_sclk;
    logic              s_csn;
    logic              s_rstn;
    logic              s_shut;
    logic              s_vs;
    logic              s_dclk;
    logic              vs_fall;
    logic              dclk_rise;
    logic              sclk_rise;
    logic              showing;

    if (RAMP_CYC < 1) begin : g_bad_ramp
        $error("lps_panel_dev: RAMP_CYC must be at least 1");
    end

    assign raw = {LINK.pixel_data, LINK.serial_data_in, LINK.serial_clock,
                  LINK.serial_select_n, LINK.panel_reset_n, LINK.shutdown,
                  LINK.vertical_sync, LINK.pixel_clock_in};

    lps_sync2 #(
        .W (SYNC_W)
    ) u_sync (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .d_i    (raw),
        .q_o    (synced)
    );

    assign {s_pix, s_sdi, s_sclk, s_csn, s_rstn, s_shut, s_vs, s_dclk} = synced;

    // edges found by comparing the stable stage with one more register
    assign vs_fall   = r_ff.vs_q & ~s_vs;
    assign dclk_rise = ~r_ff.dclk_q & s_dclk;
    assign sclk_rise = ~r_ff.sclk_q & s_sclk;
    assign showing   = (r_ff.st == D_SHOW) || (r_ff.st == D_FADE);

    always_comb begin
        nxt_r        = r_ff;
        nxt_r.dclk_q = s_dclk;
        nxt_r.vs_q   = s_vs;
        nxt_r.sclk_q = s_sclk;
        nxt_r.wvalid = 1'b0;
        nxt_r.pstb   = 1'b0;

        case (r_ff.st)
            D_OFF: begin
                nxt_r.pwr = 1'b0;
                if (!s_shut) begin
                    nxt_r.st   = D_RAMP;
                    nxt_r.vcnt = '0;
                    nxt_r.tmr  = '0;
                end
            end
            D_RAMP: begin
                if (r_ff.tmr != TW'(RAMP_CYC)) begin
                    nxt_r.tmr = r_ff.tmr + TW'(1);
                end
                // supply ramp never outlasts its bound, frames or not
                if (r_ff.tmr == TW'(RAMP_CYC - 1)) begin
                    nxt_r.pwr = 1'b1;
                end
                if (vs_fall) begin
                    nxt_r.vcnt = r_ff.vcnt + 4'h1;
                    if (r_ff.vcnt == 4'(START_FRAMES - 1)) begin
                        nxt_r.st  = D_SHOW;
                        nxt_r.pwr = 1'b1;
                    end
                end
                if (s_shut) begin
                    nxt_r.st = D_OFF;
                end
            end
            D_SHOW: begin
                if (s_shut) begin
                    nxt_r.st   = D_FADE;
                    nxt_r.vcnt = '0;
                end
            end
            D_FADE: begin
                if (vs_fall) begin
                    nxt_r.vcnt = r_ff.vcnt + 4'h1;
                    if (r_ff.vcnt == 4'(OFF_FRAMES - 1)) begin
                        nxt_r.st  = D_OFF;
                        nxt_r.pwr = 1'b0;
                    end
                end
            end
            default: begin
                nxt_r.st = D_OFF;
            end
        endcase

        // dot data taken on the synced dot clock rise; blank forces black
        if (dclk_rise) begin
            nxt_r.pix  = showing ? s_pix : '0;
            nxt_r.pstb = 1'b1;
        end

        if (s_csn) begin
            nxt_r.bitcnt = '0;
        end else if (sclk_rise) begin
            nxt_r.sh = {r_ff.sh[SER_BITS-2:0], s_sdi};
            if (r_ff.bitcnt == 4'(SER_BITS - 1)) begin
                nxt_r.bitcnt  = '0;
                nxt_r.wvalid  = 1'b1;
                nxt_r.is_data = (r_ff.sh[SER_BITS-2] == FLAG_DATA);
                nxt_r.byte_q  = {r_ff.sh[6:0], s_sdi};
            end else begin
                nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
            end
        end

        // panel reset pin forces the off state (blank, powered down) and clears the serial bit count
        if (!s_rstn) begin
            nxt_r.st     = D_OFF;
            nxt_r.pwr    = 1'b0;
            nxt_r.bitcnt = '0;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            r_ff    <= '0;
            r_ff.st <= D_OFF;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign PANEL_POWER_O    = r_ff.pwr;
    assign DISPLAY_ON_O     = showing;
    // bit 0 of each group is the lsb; larger code is brighter
    assign PIX_RED_O        = r_ff.pix[RED_LSB+:CHAN_W];
    assign PIX_GREEN_O      = r_ff.pix[GREEN_LSB+:CHAN_W];
    assign PIX_BLUE_O       = r_ff.pix[BLUE_LSB+:CHAN_W];
    assign PIX_STROBE_O     = r_ff.pstb;
    assign SER_WORD_VALID_O = r_ff.wvalid;
    assign SER_IS_DATA_O    = r_ff.is_data;
    assign SER_BYTE_O       = r_ff.byte_q;
endmodule : lps_panel_dev
`default_nettype wire

/* rtl/lps_host_ctrl.sv */
// Purpose: controller end: dot clock, syncs, pixels, power and serial writes
// Assumes: user inputs are on CLK_I
// Notes:   dot clock stops only in reset and idle, after the power-down frames
`timescale 1ns/1ps
`default_nettype none
module lps_host_ctrl
    import lps_pkg::*;
#(
    parameter int DOT_HALF = 10,
    parameter int SCK_HALF = 4
) (
    input  wire logic             CLK_I,
    input  wire logic             RSTN_I,
    lps_link_if.host              LINK,
    input  wire logic             SHUT_REQ_I,
    input  wire logic [PIX_W-1:0] PIX_I,
    output logic                  PIX_REQ_O,
    output logic                  PANEL_ON_O,
    input  wire logic             CMD_VALID_I,
    input  wire logic             CMD_IS_DATA_I,
    input  wire logic [7:0]       CMD_BYTE_I,
    output logic                  CMD_READY_O
);
    typedef enum logic [4:0] {
        H_RST    = 5'h01,
        H_IDLE   = 5'h02,
        H_SETTLE = 5'h04,
        H_ON     = 5'h08,
        H_DOWN   = 5'h10
    } lps_host_state_type;

    typedef struct packed {
        lps_host_state_type st;
        logic [9:0]         tmr;
        logic [1:0]         vcnt;
        logic [4:0]         div;
        logic               dclk;
        logic [8:0]         x;
        logic [7:0]         y;
        logic               hs;
        logic               vs;
        logic [PIX_W-1:0]   pix;
        logic               preq;
        logic               shut;
        logic               prst_n;
        logic               busy;
        logic [3:0]         sbit;
        logic [3:0]         sdiv;
        logic               sclk;
        logic               csn;
        logic [SER_BITS-1:0] sh;
    } lps_host_regs_type;

    lps_host_regs_type r_ff;
    lps_host_regs_type nxt_r;
    logic [8:0]        nx;
    logic [7:0]        ny;
    logic              run;

    if (DOT_HALF < 2 || DOT_HALF > 31 || SCK_HALF < 3 || SCK_HALF > 15) begin : g_bad
        $error("lps_host_ctrl: divider out of range");
    end

    assign run = (r_ff.st != H_IDLE) && (r_ff.st != H_RST);

    always_comb begin
        nxt_r      = r_ff;
        nxt_r.preq = 1'b0;
        nx         = (r_ff.x == 9'(LINE_DOTS - 1)) ? 9'h000 : r_ff.x + 9'h001;
        ny         = r_ff.y;
        if (r_ff.x == 9'(LINE_DOTS - 1)) begin
            ny = (r_ff.y == 8'(FRAME_LINES - 1)) ? 8'h00 : r_ff.y + 8'h01;
        end

        if (!run) begin
            nxt_r.div  = '0;
            nxt_r.dclk = 1'b0;
        end else if (r_ff.div == 5'(DOT_HALF - 1)) begin
            nxt_r.div  = '0;
            nxt_r.dclk = ~r_ff.dclk;
            // everything changes on the falling dot edge, panel samples rising
            if (r_ff.dclk) begin
                nxt_r.x  = nx;
                nxt_r.y  = ny;
                nxt_r.hs = (nx >= 9'(HSYNC_DOTS));
                nxt_r.vs = (ny >= 8'(VSYNC_LINES));
                nxt_r.pix = '0;
                if (nx >= 9'(HBP_DOTS) && nx < 9'(HBP_DOTS + HDISP_DOTS) &&
                    ny >= 8'(VBP_LINES) && ny < 8'(VBP_LINES + VDISP_LINES)) begin
                    nxt_r.pix  = PIX_I;
                    nxt_r.preq = 1'b1;
                end
                if (r_ff.vs && ny < 8'(VSYNC_LINES) && r_ff.st == H_DOWN) begin
                    nxt_r.vcnt = r_ff.vcnt + 2'h1;
                end
            end
        end else begin
            nxt_r.div = r_ff.div + 5'h01;
        end

        case (r_ff.st)
            H_RST: begin
                nxt_r.prst_n = 1'b0;
                nxt_r.shut   = 1'b1;
                nxt_r.tmr    = r_ff.tmr + 10'h001;
                if (r_ff.tmr == 10'(RES_CYC - 1)) begin
                    nxt_r.st     = H_IDLE;
                    nxt_r.prst_n = 1'b1;
                end
            end
            H_IDLE: begin
                if (!SHUT_REQ_I) begin
                    nxt_r.st  = H_SETTLE;
                    nxt_r.tmr = '0;
                end
            end
            H_SETTLE: begin
                nxt_r.tmr = r_ff.tmr + 10'h001;
                // settle time spans several dot periods with the clock running
                if (r_ff.tmr == 10'(SETTLE_CYC - 1)) begin
                    nxt_r.st   = SHUT_REQ_I ? H_DOWN : H_ON;
                    nxt_r.shut = SHUT_REQ_I;
                    nxt_r.vcnt = '0;
                end
            end
            H_ON: begin
                if (SHUT_REQ_I) begin
                    nxt_r.st   = H_DOWN;
                    nxt_r.shut = 1'b1;
                    nxt_r.vcnt = '0;
                end
            end
            H_DOWN: begin
                // one extra fall so two whole frames pass before clock stop
                if (r_ff.vcnt == 2'(OFF_FRAMES + 1)) begin
                    nxt_r.st  = H_RST;
                    nxt_r.tmr = '0;
                end
            end
            default: begin
                nxt_r.st = H_RST;
            end
        endcase

        if (!r_ff.busy) begin
            if (CMD_VALID_I) begin
                nxt_r.busy = 1'b1;
                nxt_r.csn  = 1'b0;
                nxt_r.sh   = {CMD_IS_DATA_I, CMD_BYTE_I};
                nxt_r.sbit = '0;
                nxt_r.sdiv = '0;
                nxt_r.sclk = 1'b0;
            end
        end else if (r_ff.sdiv == 4'(SCK_HALF - 1)) begin
            nxt_r.sdiv = '0;
            if (r_ff.sbit == 4'(SER_BITS)) begin
                nxt_r.busy = 1'b0;
            end else if (!r_ff.sclk) begin
                nxt_r.sclk = 1'b1;
            end else begin
                nxt_r.sclk = 1'b0;
                nxt_r.sbit = r_ff.sbit + 4'h1;
                nxt_r.sh   = {r_ff.sh[SER_BITS-2:0], 1'b0};
                if (r_ff.sbit == 4'(SER_BITS - 1)) begin
                    nxt_r.csn = 1'b1;
                end
            end
        end else begin
            nxt_r.sdiv = r_ff.sdiv + 4'h1;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            r_ff      <= '0;
            r_ff.st   <= H_RST;
            r_ff.shut <= 1'b1;
            r_ff.hs   <= 1'b1;
            r_ff.vs   <= 1'b1;
            r_ff.csn  <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign LINK.pixel_clock_in  = r_ff.dclk;
    assign LINK.horizontal_sync = r_ff.hs;
    assign LINK.vertical_sync   = r_ff.vs;
    assign LINK.pixel_data      = r_ff.pix;
    assign LINK.shutdown        = r_ff.shut;
    assign LINK.panel_reset_n   = r_ff.prst_n;
    assign LINK.serial_select_n = r_ff.csn;
    assign LINK.serial_clock    = r_ff.sclk;
    assign LINK.serial_data_in  = r_ff.sh[SER_BITS-1];
    assign PIX_REQ_O            = r_ff.preq;
    assign PANEL_ON_O           = (r_ff.st == H_ON);
    assign CMD_READY_O          = ~r_ff.busy;
endmodule : lps_host_ctrl
`default_nettype wire

/* verification/lps_link_assertions.sv */
// Purpose: wire checks on the link between host and panel ends
// Assumes: host clock samples every link wire checked here; vertical sync and pixel data are not connected
// Notes:   frame gap figure of 4 is the select gap at the SCK_HALF minimum of 3
`timescale 1ns/1ps
`default_nettype none
module lps_link_assertions
    import lps_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic RSTN_I,
    input  wire logic pixel_clock_in,
    input  wire logic horizontal_sync,
    input  wire logic shutdown,
    input  wire logic panel_reset_n,
    input  wire logic serial_select_n,
    input  wire logic serial_clock,
    input  wire logic serial_data_in
);
    logic [3:0] bit_cnt_ff;
    logic [1:0] hs_cnt_ff;
    logic [8:0] ln_cnt_ff;
    logic       ln_ok_ff;
    logic [7:0] hi_cnt_ff;
    logic       dk_seen_ff;

    // the first line after start is partial, so it is not judged
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bit_cnt_ff <= 4'h0;
            hs_cnt_ff  <= 2'h0;
            ln_cnt_ff  <= 9'h000;
            ln_ok_ff   <= 1'b0;
            hi_cnt_ff  <= 8'h00;
            dk_seen_ff <= 1'b0;
        end else begin
            bit_cnt_ff <= serial_select_n ? 4'h0 : bit_cnt_ff + {3'h0, $rose(serial_clock)};
            hs_cnt_ff  <= $fell(horizontal_sync) ? 2'h0 :
                          hs_cnt_ff + {1'h0, !horizontal_sync && $rose(pixel_clock_in)};
            ln_cnt_ff  <= $fell(horizontal_sync) ? 9'h000 :
                          ln_cnt_ff + {8'h00, $rose(pixel_clock_in)};
            ln_ok_ff   <= ln_ok_ff | $fell(horizontal_sync);
            hi_cnt_ff  <= !(shutdown && panel_reset_n) ? 8'h00 :
                          (hi_cnt_ff == 8'hFF) ? hi_cnt_ff : hi_cnt_ff + 8'h01;
            dk_seen_ff <= dk_seen_ff | $rose(pixel_clock_in);
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    a_sclk_idle_low: assert property (serial_select_n |-> !serial_clock)
        else $error("serial clock moved outside a frame");
    a_sdi_hold_high: assert property (!serial_select_n && serial_clock && $past(serial_clock)
        |-> $stable(serial_data_in)) else $error("serial data changed while clock high");
    a_word_nine_bits: assert property ($rose(serial_select_n) |-> bit_cnt_ff == SER_BITS)
        else $error("serial frame without nine clock rises");
    a_frame_gap_min: assert property ($rose(serial_select_n) |-> serial_select_n[*4])
        else $error("select high gap too short");
    a_hsync_one_dot: assert property ($rose(horizontal_sync) |-> hs_cnt_ff == 2'h1)
        else $error("line sync not one dot wide");
    a_line_dot_count: assert property ($fell(horizontal_sync) && ln_ok_ff
        |-> ln_cnt_ff == LINE_DOTS) else $error("line length wrong");
    a_dot_before_shut: assert property ($fell(shutdown) |-> dk_seen_ff)
        else $error("shutdown lowered before dot clock ran");
    a_shut_settle: assert property ($fell(shutdown) |-> hi_cnt_ff >= SETTLE_CYC)
        else $error("shutdown lowered too soon");
endmodule : lps_link_assertions
`default_nettype wire

/* verification/testbench.sv */
// Purpose: host and panel joined on one link, second panel driven by the bench
// Assumes: frames are far too long to simulate, so the bench panel gets short frames
// Notes:   host power-down is entered but not waited out
`timescale 1ns/1ps
`default_nettype none
module testbench
    import lps_pkg::*;
;
    localparam int RAMP = 2000;
    localparam logic [17:0] PV [7] = '{18'h00000, 18'h3FFFF, 18'h0003F, 18'h00FC0,
                                       18'h3F000, 18'h00001, 18'h20820};
    logic clk, rstn, shut_req, cmd_valid, cmd_is_data, pix_req, panel_on, cmd_ready;
    logic [7:0] cmd_byte, by1, by2;
    logic [PIX_W-1:0] pix;
    logic pw1, on1, stb1, wv1, isd1, pw2, on2, stb2, wv2, isd2;
    logic [5:0] r1, g1, b1, r2, g2, b2;
    int num_errors, cmp_count, n;
    int wv2_cnt = 0;

    lps_link_if link1 ();
    lps_link_if link2 ();
    lps_host_ctrl #(.DOT_HALF(2)) lps_host_ctrl_i (.CLK_I(clk), .RSTN_I(rstn), .LINK(link1),
        .SHUT_REQ_I(shut_req), .PIX_I(pix), .PIX_REQ_O(pix_req), .PANEL_ON_O(panel_on),
        .CMD_VALID_I(cmd_valid), .CMD_IS_DATA_I(cmd_is_data), .CMD_BYTE_I(cmd_byte),
        .CMD_READY_O(cmd_ready));
    lps_panel_dev #(.RAMP_CYC(RAMP)) lps_panel_dev_i (.CLK_I(clk), .RSTN_I(rstn),
        .LINK(link1), .PANEL_POWER_O(pw1), .DISPLAY_ON_O(on1), .PIX_RED_O(r1),
        .PIX_GREEN_O(g1), .PIX_BLUE_O(b1), .PIX_STROBE_O(stb1), .SER_WORD_VALID_O(wv1),
        .SER_IS_DATA_O(isd1), .SER_BYTE_O(by1));
    lps_panel_dev #(.RAMP_CYC(100000)) lps_panel_dev2_i (.CLK_I(clk), .RSTN_I(rstn),
        .LINK(link2), .PANEL_POWER_O(pw2), .DISPLAY_ON_O(on2), .PIX_RED_O(r2),
        .PIX_GREEN_O(g2), .PIX_BLUE_O(b2), .PIX_STROBE_O(stb2), .SER_WORD_VALID_O(wv2),
        .SER_IS_DATA_O(isd2), .SER_BYTE_O(by2));
    lps_link_assertions lps_link_assertions_i (.CLK_I(clk), .RSTN_I(rstn),
        .pixel_clock_in(link1.pixel_clock_in), .horizontal_sync(link1.horizontal_sync),
        .shutdown(link1.shutdown), .panel_reset_n(link1.panel_reset_n),
        .serial_select_n(link1.serial_select_n), .serial_clock(link1.serial_clock),
        .serial_data_in(link1.serial_data_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // bench dot clock, unrelated in phase to clk
    initial begin
        link2.pixel_clock_in = 1'b0;
        #3;
        forever #40 link2.pixel_clock_in = ~link2.pixel_clock_in;
    end
    always @(posedge clk) begin
        if (wv2 === 1'b1) begin
            wv2_cnt++;
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic send_cmd(input logic f, input logic [7:0] b);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 200) begin
            cyc(1);
            k++;
        end
        cmd_valid   <= 1'b1;
        cmd_is_data <= f;
        cmd_byte    <= b;
        cyc(1);
        cmd_valid <= 1'b0;
        k = 0;
        while (wv1 !== 1'b1 && k < 300) begin
            cyc(1);
            k++;
        end
        chk("word valid", 18'h1, {17'h0, wv1});
        chk("word flag", {17'h0, f}, {17'h0, isd1});
        chk("word byte", {10'h0, b}, {10'h0, by1});
    endtask : send_cmd

    // nb below nine leaves a partial word that must be thrown away
    task automatic ser2(input logic [8:0] w, input int nb);
        link2.serial_select_n <= 1'b0;
        for (int i = 8; i > 8 - nb; i--) begin
            link2.serial_data_in <= w[i];
            link2.serial_clock   <= 1'b0;
            cyc(4);
            link2.serial_clock <= 1'b1;
            cyc(4);
        end
        link2.serial_clock <= 1'b0;
        cyc(4);
        link2.serial_select_n <= 1'b1;
        link2.serial_data_in  <= ~w[9-nb];
        cyc(8);
    endtask : ser2

    task automatic vfall2(input int k);
        repeat (k) begin
            link2.vertical_sync <= 1'b0;
            cyc(20);
            link2.vertical_sync <= 1'b1;
            cyc(20);
        end
    endtask : vfall2

    task automatic pix2(input logic [17:0] v, input logic sh);
        link2.pixel_data <= v;
        cyc(40);
        chk("red", sh ? {12'h0, v[RED_LSB +: CHAN_W]} : 18'h0, {12'h0, r2});
        chk("green", sh ? {12'h0, v[GREEN_LSB +: CHAN_W]} : 18'h0, {12'h0, g2});
        chk("blue", sh ? {12'h0, v[BLUE_LSB +: CHAN_W]} : 18'h0, {12'h0, b2});
    endtask : pix2

    initial begin
        #500000;
        num_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        give_verdict();
    end

    initial begin
        rstn = 1'b0;
        shut_req = 1'b1;
        cmd_valid = 1'b0;
        cmd_is_data = 1'b0;
        cmd_byte = 8'h00;
        pix = 18'h2A5C3;
        num_errors = 0;
        cmp_count = 0;
        link2.horizontal_sync = 1'b1;
        link2.vertical_sync = 1'b1;
        link2.pixel_data = 18'h00000;
        link2.shutdown = 1'b1;
        link2.panel_reset_n = 1'b0;
        link2.serial_select_n = 1'b1;
        link2.serial_clock = 1'b0;
        link2.serial_data_in = 1'b0;
        cyc(8);
        rstn <= 1'b1;
        link2.panel_reset_n <= 1'b1;
        n = 0;
        while (link1.panel_reset_n !== 1'b1 && n < 1500) begin
            cyc(1);
            n++;
        end
        send_cmd(1'b0, 8'hA5);
        send_cmd(1'b1, 8'h3C);
        send_cmd(1'b1, 8'h80);
        send_cmd(1'b0, 8'h01);
        // clocks with select high, then a partial word, then two whole ones
        repeat (9) begin
            link2.serial_clock   <= ~link2.serial_clock;
            link2.serial_data_in <= ~link2.serial_data_in;
            cyc(4);
        end
        link2.serial_clock <= 1'b0;
        cyc(4);
        ser2(9'h1FF, 5);
        chk("no stray word", 18'h0, wv2_cnt[17:0]);
        ser2(9'h1C3, 9);
        chk("one word", 18'h1, wv2_cnt[17:0]);
        chk("flag data", 18'h1, {17'h0, isd2});
        chk("byte", 18'h0C3, {10'h0, by2});
        ser2(9'h05A, 9);
        chk("flag index", 18'h0, {17'h0, isd2});
        chk("byte", 18'h05A, {10'h0, by2});
        link2.shutdown <= 1'b0;
        // a sync fall in the same cycle as the shutdown edge is not counted
        cyc(8);
        vfall2(9);
        chk("display early", 18'h0, {17'h0, on2});
        vfall2(1);
        chk("display tenth", 18'h1, {17'h0, on2});
        chk("power tenth", 18'h1, {17'h0, pw2});
        for (int i = 0; i < 7; i++) begin
            pix2(PV[i], 1'b1);
        end
        link2.shutdown <= 1'b1;
        cyc(8);
        vfall2(1);
        chk("display first fall", 18'h1, {17'h0, on2});
        vfall2(1);
        chk("display second fall", 18'h0, {17'h0, on2});
        pix2(18'h3FFFF, 1'b0);
        shut_req <= 1'b0;
        n = 0;
        while (link1.shutdown !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (pw1 !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        chk("ramp length", 18'h1, {17'h0, n >= RAMP - 5 && n <= RAMP + 10});
        chk("panel on", 18'h1, {17'h0, panel_on});
        chk("display off in ramp", 18'h0, {17'h0, on1});
        n = 0;
        while (link1.pixel_data === 18'h0 && n < 8000) begin
            cyc(1);
            n++;
        end
        chk("host pixel bus", pix, link1.pixel_data);
        chk("pixel request", 18'h1, {17'h0, pix_req});
        shut_req <= 1'b1;
        cyc(10);
        chk("shutdown high", 18'h1, {17'h0, link1.shutdown});
        chk("power dropped", 18'h0, {17'h0, pw1});
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
